/* cts_charge_timers.sv */
/*
  Charge termination, top-off timer and three safety timers with an
  Avalon-MM register slave. Analog condition inputs are asynchronous
  and are synchronised here; the bus runs on the same clock.
*/
// Contract
// - Terminate only at high voltage, CV, low current
// - After termination battery switch off, supplement re-enables
// - Termination sets code 111 and pulses interrupt
// - Regulation loops suppress termination
// - Termination enable clear defers after termination
// - Top-off keeps CV charging until time expires
// - Top-off timer follows safety suspend and half rate
// - Top-off shows 110, expiry gives 111 and interrupt
// - Top-off clears on enable, termination, register reset
// - Top-off duration captured at termination
// - Top-off starts only after real termination
// - Top-off start/expiry pulse; mask hides charge pulses
// - Fast timer expiry sets fault flag, interrupt
// - Trickle 1h, pre 2h/0.5h, fast default 12h
// - Timer enable bits; re-enable restarts from zero
// - Each stage starts its own safety timer
// - Regulation with half-rate enable halves timer speed
// - Half rate persists until regulation ends
// - Faults freeze timers, ignore half rate
// - Pre and trickle timers share fast rules
// - Fast timer reset events
// - Pre and trickle timer reset events
// - Three-bit phase code encoding
`timescale 1ns/1ps
module cts_charge_timers #(
  parameter int TICK_CYCLES = cts_pkg::CTS_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic vbat_above_recharge,
  input wire logic cv_regulation,
  input wire logic current_below_term,
  input wire logic input_current_limit_regulation,
  input wire logic input_voltage_limit_regulation,
  input wire logic thermal_regulation,
  input wire logic [1:0] battery_stage,
  input wire logic charge_disable_n,
  input wire logic charge_fault,
  input wire logic supplement_request,
  output logic [2:0] charge_phase_code,
  output logic battery_switch,
  output logic fast_timer_expired_flag,
  output logic int_pulse
);
  import cts_pkg::*;

  function automatic cts_state_t stage_state(input logic [1:0] s);
    if (s == 2'b00) begin
      return ST_TRICKLE;
    end else if (s == 2'b01) begin
      return ST_PRE;
    end
    return ST_FAST;
  endfunction

  function automatic logic [16:0] fast_limit(input logic [1:0] s);
    case (s)
      2'b00: return CTS_FAST_S0;
      2'b01: return CTS_FAST_S1;
      2'b10: return CTS_FAST_S2;
      default: return CTS_FAST_S3;
    endcase
  endfunction

  // Pin inputs, two flops each
  logic [10:0] sync1_reg;
  logic [10:0] sync2_reg;
  wire [10:0] pins = {supplement_request, charge_fault, charge_disable_n,
    battery_stage, thermal_regulation, input_voltage_limit_regulation,
    input_current_limit_regulation, current_below_term, cv_regulation,
    vbat_above_recharge};
  wire s_above = sync2_reg[0];
  wire s_cv = sync2_reg[1];
  wire s_below = sync2_reg[2];
  wire s_reg_any = |sync2_reg[5:3];
  wire [1:0] s_stage = sync2_reg[7:6];
  wire s_ce_n = sync2_reg[8];
  wire s_fault = sync2_reg[9];
  wire s_supp = sync2_reg[10];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (clk_en) begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  // Bus slave: one wait cycle, then answer
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [13:0] ctrl_reg;
  logic [2:0] flag_reg;
  wire req = avs_read | avs_write;
  wire take = req & ack_reg;
  wire wr_ctrl = take & avs_write & (avs_address == CTS_OFS_CTRL);
  wire wr_flags = take & avs_write & (avs_address == CTS_OFS_FLAGS);
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [13:0] ctrl_wr = (ctrl_reg & ~be_mask[13:0]) |
    (avs_writedata[13:0] & be_mask[13:0]);
  wire reg_rst = wr_ctrl & ctrl_wr[CB_REG_RST];
  wire [2:0] flag_clr = wr_flags ? (avs_writedata[2:0] & be_mask[2:0]) : 3'h0;

  assign avs_waitrequest = ~ack_reg;
  assign avs_readdata = rdata_reg;

  wire c_allow = ctrl_reg[CB_ALLOW];
  wire c_term = ctrl_reg[CB_TERM];
  wire c_topoff = ctrl_reg[CB_TOPOFF];
  wire c_half = ctrl_reg[CB_HALF];
  wire [2:0] c_tmr_en = ctrl_reg[CB_FAST_EN:CB_TRK_EN];
  wire c_mask = ctrl_reg[CB_MASK];
  wire c_pre_dur = ctrl_reg[CB_PRE_DUR];
  wire [1:0] c_fast = ctrl_reg[CB_FAST_LO+1:CB_FAST_LO];
  wire [1:0] c_top = ctrl_reg[CB_TOP_LO+1:CB_TOP_LO];

  // Core state
  cts_state_t st_reg;
  cts_state_t st_next;
  logic half_active_reg;
  logic half_phase_reg;
  logic term_en_reg;
  logic topoff_en_reg;
  logic [1:0] top_set_reg;
  logic [16:0] top_cnt_reg;
  logic [1:0] stage_prev_reg;
  logic [1:0] fast_set_prev_reg;
  logic pre_set_prev_reg;
  logic [2:0] en_prev_reg;
  logic [2:0] phase_prev_reg;
  logic int_reg;
  logic [31:0] tick_cnt_reg;
  logic tick_reg;

  wire [2:0] status_ph;
  wire [31:0] status_word = {23'h0, st_reg == ST_TOPOFF, term_en_reg,
    half_active_reg, battery_switch, 2'b00, status_ph};
  wire [31:0] rd_mux = (avs_address == CTS_OFS_CTRL) ? {18'h0, ctrl_reg} :
    (avs_address == CTS_OFS_STATUS) ? status_word :
    (avs_address == CTS_OFS_FLAGS) ? {29'h0, flag_reg} : 32'h0;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_reg <= req & ~ack_reg;
      if (req & ~ack_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Register reset request restores defaults, top-off off
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= CTS_CTRL_RESET;
    end else if (clk_en) begin
      if (reg_rst) begin
        ctrl_reg <= CTS_CTRL_RESET;
      end else if (wr_ctrl) begin
        ctrl_reg <= ctrl_wr;
      end
    end
  end

  // Common timebase
  wire tick_wrap = tick_cnt_reg == 32'(TICK_CYCLES - 1);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else if (clk_en) begin
      tick_cnt_reg <= tick_wrap ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
      tick_reg <= tick_wrap;
    end
  end

  // Half rate: latched on entry, held until regulation ends
  wire half_next = s_reg_any & (half_active_reg | c_half);
  wire adv = tick_reg & ~s_fault & (~half_active_reg | half_phase_reg);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      half_active_reg <= 1'b0;
      half_phase_reg <= 1'b0;
    end else if (clk_en && !s_fault) begin
      half_active_reg <= half_next;
      if (tick_reg) begin
        half_phase_reg <= ~half_phase_reg;
      end
    end
  end

  // Cycle control
  wire chg_on = c_allow & s_ce_n;
  wire charging = (st_reg == ST_TRICKLE) | (st_reg == ST_PRE) |
    (st_reg == ST_FAST) | (st_reg == ST_CV);
  wire any_flag = |flag_reg;
  wire start = chg_on & ~any_flag &
    ((st_reg == ST_IDLE) | ((st_reg == ST_DONE) & ~s_above));
  wire term_ok = s_above & s_cv & s_below & ~s_reg_any & term_en_reg;
  wire [16:0] top_lim = CTS_TOP_STEP_S * 17'({15'h0, top_set_reg} + 17'd1);
  wire top_exp = (st_reg == ST_TOPOFF) & (top_cnt_reg >= top_lim);
  wire [2:0] tmr_exp;
  wire stg_chg = charging & (s_stage != stage_prev_reg);
  wire tp_chg = stg_chg & ~s_stage[1] & ~stage_prev_reg[1];
  wire pf_chg = stg_chg & (s_stage[1] ^ stage_prev_reg[1]) &
    ((s_stage == 2'b01) | (stage_prev_reg == 2'b01));

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: begin
        if (start) begin
          st_next = stage_state(s_stage);
        end
      end
      ST_TRICKLE, ST_PRE, ST_FAST, ST_CV: begin
        if (!chg_on || (|tmr_exp)) begin
          st_next = ST_IDLE;
        end else if (st_reg == ST_CV && term_ok) begin
          st_next = topoff_en_reg ? ST_TOPOFF : ST_DONE;
        end else if (stg_chg) begin
          st_next = stage_state(s_stage);
        end else if (st_reg == ST_FAST && s_cv) begin
          st_next = ST_CV;
        end else if (st_reg == ST_CV && !s_cv) begin
          st_next = ST_FAST;
        end
      end
      ST_TOPOFF: begin
        if (!chg_on) begin
          st_next = ST_IDLE;
        end else if (top_exp) begin
          st_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!chg_on) begin
          st_next = ST_IDLE;
        end else if (start) begin
          st_next = stage_state(s_stage);
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  wire term_hit = (st_reg == ST_CV) & (st_next != ST_CV) &
    (st_next != ST_FAST) & (st_next != ST_IDLE);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= ST_IDLE;
      stage_prev_reg <= 2'b00;
    end else if (clk_en) begin
      st_reg <= st_next;
      stage_prev_reg <= s_stage;
    end
  end

  // Termination enable: clear defers once terminated
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      term_en_reg <= 1'b1;
    end else if (clk_en) begin
      if (start || c_term) begin
        term_en_reg <= c_term;
      end else if (st_reg != ST_TOPOFF && st_reg != ST_DONE) begin
        term_en_reg <= 1'b0;
      end
    end
  end

  // Top-off enable captured on cycle start and termination, duration only at termination
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      topoff_en_reg <= 1'b0;
      top_set_reg <= 2'b00;
      top_cnt_reg <= 17'h0_0000;
    end else if (clk_en) begin
      if (reg_rst) begin
        topoff_en_reg <= 1'b0;
        top_cnt_reg <= 17'h0_0000;
      end else if (start || term_hit) begin
        topoff_en_reg <= c_topoff;
        top_cnt_reg <= 17'h0_0000;
        if (term_hit) begin
          top_set_reg <= c_top;
        end
      end else if (st_reg == ST_TOPOFF && adv && !top_exp) begin
        top_cnt_reg <= top_cnt_reg + 17'h0_0001;
      end
    end
  end

  // Safety timers: 0 trickle, 1 pre-charge, 2 fast
  wire [2:0] tmr_run = {(st_reg == ST_FAST) | (st_reg == ST_CV),
    st_reg == ST_PRE, st_reg == ST_TRICKLE};
  wire [16:0] tmr_lim [3];
  assign tmr_lim[0] = CTS_TRICKLE_S;
  assign tmr_lim[1] = c_pre_dur ? CTS_PRE_SHORT_S : CTS_PRE_LONG_S;
  assign tmr_lim[2] = fast_limit(c_fast);
  wire [2:0] tmr_clr;
  assign tmr_clr[0] = start | tp_chg;
  assign tmr_clr[1] = start | tp_chg | pf_chg |
    (c_pre_dur != pre_set_prev_reg);
  assign tmr_clr[2] = start | pf_chg | (c_fast != fast_set_prev_reg);
  wire [2:0] en_rise = c_tmr_en & ~en_prev_reg;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_tmr
      logic [16:0] cnt_reg;
      assign tmr_exp[gi] = tmr_run[gi] & c_tmr_en[gi] &
        (cnt_reg >= tmr_lim[gi]);
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          cnt_reg <= 17'h0_0000;
        end else if (clk_en) begin
          if (tmr_clr[gi] || en_rise[gi]) begin
            cnt_reg <= 17'h0_0000;
          end else if (tmr_run[gi] && c_tmr_en[gi] && adv) begin
            cnt_reg <= cnt_reg + 17'h0_0001;
          end
        end
      end
    end
  endgenerate

  // Sticky expiry flags; set beats a same-cycle clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= 3'h0;
      en_prev_reg <= 3'h0;
      fast_set_prev_reg <= 2'b10;
      pre_set_prev_reg <= 1'b0;
    end else if (clk_en) begin
      flag_reg <= tmr_exp | (flag_reg & ~flag_clr);
      en_prev_reg <= c_tmr_en;
      fast_set_prev_reg <= c_fast;
      pre_set_prev_reg <= c_pre_dur;
    end
  end

  // Phase code and interrupt
  assign status_ph = (st_reg == ST_TRICKLE) ? PH_TRICKLE :
    (st_reg == ST_PRE) ? PH_PRE :
    (st_reg == ST_FAST) ? PH_FAST :
    (st_reg == ST_CV) ? PH_CV :
    (st_reg == ST_TOPOFF) ? PH_TOPOFF :
    (st_reg == ST_DONE) ? PH_DONE : PH_IDLE;
  // Charge pulses come from code changes, so top-off start is one too
  wire ph_evt = (status_ph != phase_prev_reg) & ~c_mask;
  wire fast_evt = tmr_exp[2] & ~flag_reg[2];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_prev_reg <= PH_IDLE;
      int_reg <= 1'b0;
    end else if (clk_en) begin
      phase_prev_reg <= status_ph;
      // Back-to-back events merge, so the pulse never runs two cycles
      int_reg <= (ph_evt | fast_evt) & ~int_reg;
    end
  end

  // Battery switch off after termination unless supplementing
  assign battery_switch = charging | (st_reg == ST_TOPOFF) | s_supp;
  assign charge_phase_code = phase_prev_reg;
  assign fast_timer_expired_flag = flag_reg[2];
  assign int_pulse = int_reg;
endmodule

/* cts_pkg.sv */
/*
  Shared constants for the charge termination and safety timer block.
  Assumes a 200 MHz clock and a one second timer tick.
*/
package cts_pkg;
  localparam logic [3:0] CTS_OFS_CTRL = 4'h0;
  localparam logic [3:0] CTS_OFS_STATUS = 4'h4;
  localparam logic [3:0] CTS_OFS_FLAGS = 4'h8;
  localparam int CTS_CTRL_W = 14;
  localparam int CB_ALLOW = 0;
  localparam int CB_TERM = 1;
  localparam int CB_TOPOFF = 2;
  localparam int CB_HALF = 3;
  localparam int CB_TRK_EN = 4;
  localparam int CB_PRE_EN = 5;
  localparam int CB_FAST_EN = 6;
  localparam int CB_MASK = 7;
  localparam int CB_PRE_DUR = 8;
  localparam int CB_FAST_LO = 9;
  localparam int CB_TOP_LO = 11;
  localparam int CB_REG_RST = 13;
  localparam logic [13:0] CTS_CTRL_RESET = 14'h047b;
  localparam longint CTS_CLK_HZ = 200_000_000;
  localparam longint CTS_TICK_S = 1;
  localparam int CTS_TICK_CYCLES = int'(CTS_TICK_S * CTS_CLK_HZ);
  localparam int CTS_CNT_W = 17;
  localparam logic [16:0] CTS_TRICKLE_S = 17'd3600;
  localparam logic [16:0] CTS_PRE_LONG_S = 17'd7200;
  localparam logic [16:0] CTS_PRE_SHORT_S = 17'd1800;
  localparam logic [16:0] CTS_FAST_S0 = 17'd18000;
  localparam logic [16:0] CTS_FAST_S1 = 17'd28800;
  localparam logic [16:0] CTS_FAST_S2 = 17'd43200;
  localparam logic [16:0] CTS_FAST_S3 = 17'd86400;
  localparam logic [16:0] CTS_TOP_STEP_S = 17'd900;
  localparam logic [2:0] PH_IDLE = 3'h0;
  localparam logic [2:0] PH_TRICKLE = 3'h1;
  localparam logic [2:0] PH_PRE = 3'h2;
  localparam logic [2:0] PH_FAST = 3'h3;
  localparam logic [2:0] PH_CV = 3'h4;
  localparam logic [2:0] PH_TOPOFF = 3'h6;
  localparam logic [2:0] PH_DONE = 3'h7;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TRICKLE = 3'b001,
    ST_PRE = 3'b011,
    ST_FAST = 3'b010,
    ST_CV = 3'b110,
    ST_TOPOFF = 3'b111,
    ST_DONE = 3'b101
  } cts_state_t;
endpackage

/* cts_charge_timers_checker.sv */
/*
  Concurrent checks on the charge termination block's output ports.
  Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
module cts_charge_timers_checker #(
  parameter int TICK_CYCLES = 2
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic input_current_limit_regulation,
  input wire logic input_voltage_limit_regulation,
  input wire logic thermal_regulation,
  input wire logic supplement_request,
  input wire logic [2:0] charge_phase_code,
  input wire logic battery_switch,
  input wire logic fast_timer_expired_flag,
  input wire logic int_pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Inputs pass two sync flops, so windows below allow for that lag
  wire reg_any = input_current_limit_regulation | input_voltage_limit_regulation
    | thermal_regulation;
  property p_pulse_one;
    int_pulse |=> !int_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("int_pulse too long");
  property p_no_reserved;
    charge_phase_code != 3'h5;
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("reserved phase");
  property p_pulse_cause;
    int_pulse |-> ($changed(charge_phase_code) || $rose(fast_timer_expired_flag));
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("stray pulse");
  property p_fast_int;
    $rose(fast_timer_expired_flag) |-> int_pulse;
  endproperty
  a_fast_int: assert property (p_fast_int) else $error("no expiry pulse");
  property p_done_from;
    ($changed(charge_phase_code) && charge_phase_code == 3'h7)
      |-> ($past(charge_phase_code) inside {3'h4, 3'h6});
  endproperty
  a_done_from: assert property (p_done_from) else $error("done not from CV");
  property p_done_off;
    (charge_phase_code == 3'h7 && !supplement_request) [*5] |-> $past(!battery_switch);
  endproperty
  a_done_off: assert property (p_done_off) else $error("switch on when done");
  property p_topoff_on;
    (charge_phase_code == 3'h6) [*2] |-> $past(battery_switch);
  endproperty
  a_topoff_on: assert property (p_topoff_on) else $error("switch off in top-off");
  property p_reg_hold;
    reg_any [*6] ##1 (charge_phase_code == 3'h4) |=> (charge_phase_code != 3'h7);
  endproperty
  a_reg_hold: assert property (p_reg_hold) else $error("ended in regulation");
  c_done: cover property (charge_phase_code == 3'h7);
  c_topoff: cover property (charge_phase_code == 3'h6);
  c_fast: cover property ($rose(fast_timer_expired_flag));
endmodule

/* cts_host_model.sv */
/*
  Host model: Avalon-MM master issuing register reads and writes.
  Assumes callers enter its task just after a rising clock edge.
*/
`timescale 1ns/1ps
module cts_host_model (
  input wire logic clock,
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  output logic timed_out
);
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    timed_out = 1'b0;
  end
  // Request held until waitrequest is seen low at an edge
  task automatic xfer(input logic we, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) timed_out = 1'b1;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Extra edge so the strobe is never raised in the step it fell
    @(posedge clock);
  endtask
endmodule

/* tb_top.sv */
/*
  Self-checking bench for the charge termination and safety timers.
  Assumes a short timer tick through TICK_CYCLES to keep runs brief.
*/
`timescale 1ns/1ps
module tb_top;
  import cts_pkg::*;
  localparam int TICK_CYCLES = 2;
  typedef struct {logic [1:0] stage; logic [2:0] phase;} cts_row_t;
  cts_row_t rows[3] = '{'{2'b01, 3'h2}, '{2'b00, 3'h1}, '{2'b10, 3'h3}};
  logic clock, reset_n, vbat, cv, below, icl, dis_n, supp;
  logic [1:0] stage;
  logic [3:0] adr;
  logic rd_s, wr_s, wait_s, tmo, sw, flag, intp;
  logic [31:0] wd, rdat, q;
  logic [2:0] phase;
  int failures, checked, ints, b, n;
  cts_charge_timers #(.TICK_CYCLES(TICK_CYCLES)) cts_charge_timers_inst (
    .clock(clock), .reset_n(reset_n), .clk_en(1'b1), .avs_address(adr),
    .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(4'hF),
    .avs_readdata(rdat), .avs_waitrequest(wait_s), .vbat_above_recharge(vbat),
    .cv_regulation(cv), .current_below_term(below),
    .input_current_limit_regulation(icl), .input_voltage_limit_regulation(1'b0),
    .thermal_regulation(1'b0), .battery_stage(stage), .charge_disable_n(dis_n),
    .charge_fault(1'b0), .supplement_request(supp), .charge_phase_code(phase),
    .battery_switch(sw), .fast_timer_expired_flag(flag), .int_pulse(intp));
  cts_host_model cts_host_model_inst (.clock(clock), .avs_address(adr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wait_s), .timed_out(tmo));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) if (intp === 1'b1) ints <= ints + 1;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (tmo === 1'b1) failures++;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  // Bounded wait; running out ends the run
  task automatic wait_phase(input logic [2:0] exp, input int bound);
    n = 0;
    while (phase !== exp && n < bound) begin
      @(posedge clock);
      n++;
    end
    if (n >= bound) begin
      chk("phase wait", exp, phase);
      end_of_test();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    cts_host_model_inst.xfer(1'b1, a, d, q);
    if (tmo === 1'b1) end_of_test();
  endtask
  task automatic rd(input logic [3:0] a);
    cts_host_model_inst.xfer(1'b0, a, 32'h0000_0000, q);
    if (tmo === 1'b1) end_of_test();
  endtask
  initial begin
    failures = 0;
    checked = 0;
    ints = 0;
    {reset_n, vbat, cv, below, icl, supp} = 6'h00;
    dis_n = 1'b1;
    stage = 2'b00;
    cyc(12);
    chk("reset phase", 3'h0, phase);
    chk("reset outs", 3'h0, {sw, flag, intp});
    chk("idle wait", 1'b1, wait_s);
    reset_n <= 1'b1;
    cyc(1);
    rd(CTS_OFS_CTRL);
    chk("ctrl reset", 32'h0000_047B, q);
    rd(4'hC);
    chk("unmapped", 32'h0000_0000, q);
    $display("done: reset");
    foreach (rows[i]) begin
      b = ints;
      stage <= rows[i].stage;
      wait_phase(rows[i].phase, 50);
      cyc(3);
      chk("stage phase", rows[i].phase, phase);
      chk("stage int", b + 1, ints);
    end
    $display("done: stages");
    cv <= 1'b1;
    wait_phase(3'h4, 50);
    {icl, vbat, below} <= 3'b111;
    cyc(40);
    chk("term held", 3'h4, phase);
    b = ints;
    icl <= 1'b0;
    wait_phase(3'h7, 50);
    cyc(3);
    chk("term int", b + 1, ints);
    chk("switch off", 1'b0, sw);
    supp <= 1'b1;
    cyc(5);
    chk("switch supplement", 1'b1, sw);
    supp <= 1'b0;
    $display("done: termination");
    wr(CTS_OFS_CTRL, 32'h0000_047F);
    vbat <= 1'b0;
    wait_phase(3'h4, 50);
    b = ints;
    vbat <= 1'b1;
    wait_phase(3'h6, 50);
    cyc(3);
    chk("topoff switch", 1'b1, sw);
    chk("topoff start int", b + 1, ints);
    // Longest setting written after termination must not stretch the run
    wr(CTS_OFS_CTRL, 32'h0000_1C7F);
    wait_phase(3'h7, 4000);
    chk("topoff length", 1'b1, n > 1700 && n < 1900);
    cyc(3);
    chk("topoff end int", b + 2, ints);
    $display("done: top-off");
    wr(CTS_OFS_CTRL, 32'h0000_04F9);
    b = ints;
    vbat <= 1'b0;
    wait_phase(3'h4, 50);
    vbat <= 1'b1;
    cyc(40);
    chk("term disabled", 3'h4, phase);
    wr(CTS_OFS_CTRL, 32'h0000_04FB);
    wait_phase(3'h7, 50);
    cyc(3);
    chk("masked ints", b, ints);
    $display("done: mask");
    wr(CTS_OFS_CTRL, 32'h0000_007B);
    {cv, vbat} <= 2'b00;
    wait_phase(3'h3, 50);
    // Let the start pulse reach the counter first
    cyc(2);
    b = ints;
    n = 0;
    while (flag !== 1'b1 && n < 40000) begin
      @(posedge clock);
      n++;
    end
    chk("fast length", 1'b1, n > 35900 && n < 36100);
    if (n >= 40000) end_of_test();
    cyc(3);
    chk("fast int", b + 1, ints);
    chk("fault idle", 3'h0, phase);
    rd(CTS_OFS_FLAGS);
    chk("flags", 32'h0000_0004, q);
    wr(CTS_OFS_FLAGS, 32'h0000_0004);
    rd(CTS_OFS_FLAGS);
    chk("flags clear", 32'h0000_0000, q);
    $display("done: fast timer");
    wr(CTS_OFS_CTRL, 32'h0000_2000);
    rd(CTS_OFS_CTRL);
    chk("reg reset", 32'h0000_047B, q);
    $display("done: register reset");
    end_of_test();
  end
endmodule
bind cts_charge_timers cts_charge_timers_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_inst (
  .clock(clock), .reset_n(reset_n),
  .input_current_limit_regulation(input_current_limit_regulation),
  .input_voltage_limit_regulation(input_voltage_limit_regulation),
  .thermal_regulation(thermal_regulation), .supplement_request(supplement_request),
  .charge_phase_code(charge_phase_code), .battery_switch(battery_switch),
  .fast_timer_expired_flag(fast_timer_expired_flag), .int_pulse(int_pulse));
